// ---- ccp_pkg.sv ----
// Package for the cache coherence policy block: constants, types, register map
// Behaviour
// - Fill first level only when primary_cacheable_bit set
// - Enabled second level caches every cacheable load, store and atomic
// - Atomics execute at second level only
// - Second level coherence granule is 64 bytes
// - Directory tracks 16-byte data, 32-byte instruction lines
// - Second level not inclusive; eviction clears directory, no first-level drop
// - Modified second level line written back first
// - First level flush invalidates and updates directory
// - Direct-map fill uses address-selected way
// - Direct-map hit keeps line in current way
// - Diagnostic invalidate: no first-level drop, no writeback
// - Prefetch function 18h invalidates entry, writes back dirty
// - Total store ordering kept across cacheability
// - Noncacheable accesses complete in program order
// - Speculative side-effect load traps, not performed
// - Noncacheable transfers down to one byte
// - Lookaside barrier is a no-operation
// - Store buffer uncorrectable error traps deferred
// - Multiple lookup hit raises error trap
// - Line state bits protected by SECDED
// - Second level holds poisoned_data_marker lines
// - Atomics allocate second level, invalidate first level
package ccp_pkg;
    localparam int          WAYS        = 4;
    localparam int          SETS        = 16;
    localparam int          WAY_W       = 2;
    localparam int          SET_W       = 4;
    localparam int          TAG_W       = 20;
    localparam int          L2_LINE_B   = 64;
    localparam int          L1D_LINE_B  = 16;
    localparam int          L1I_LINE_B  = 32;
    localparam int          L2_OFF_W    = $clog2(L2_LINE_B);
    localparam int          L1D_OFF_W   = $clog2(L1D_LINE_B);
    localparam int          L1I_OFF_W   = $clog2(L1I_LINE_B);
    localparam int          ADDR_W      = TAG_W + SET_W + L2_OFF_W;
    localparam int          L1D_SUB     = L2_LINE_B / L1D_LINE_B;
    localparam int          L1I_SUB     = L2_LINE_B / L1I_LINE_B;
    localparam int          ST_W        = 4;
    localparam int          ECC_W       = 4;
    localparam logic [4:0]  PF_INVAL_FCN = 5'h18;

    // Register byte offsets, control bit positions, control reset value
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_STATUS  = 12'h004;
    localparam logic [11:0] REG_COUNT   = 12'h008;
    localparam int          CTRL_L2_EN  = 0;
    localparam int          CTRL_DMAP   = 1;
    localparam logic [1:0]  CTRL_RESET  = 2'h1;

    typedef enum logic [2:0] {
        CCP_LOAD, CCP_STORE, CCP_ATOMIC, CCP_PREFETCH, CCP_DIAG_INV, CCP_LOOKASIDE
    } ccp_op_type;

    typedef struct packed {
        ccp_op_type          op;
        logic [ADDR_W-1:0]   addr;
        logic                cp;
        logic                cacheable;
        logic                side_effect;
        logic                speculative;
        logic                instr;
        logic [4:0]          fcn;
        logic [2:0]          size_log2;
        logic                multi_hit;
        logic                sb_ue;
    } ccp_req_type;

    typedef struct packed {
        logic                done;
        logic                l1_fill;
        logic                l1_inval;
        logic                l1_instr;
        logic [ADDR_W-1:0]   l1_addr;
        logic                side_effect_page_trap;
        logic                deferred_store_fault_trap;
        logic                multi_hit_trap;
        logic                nc_page_trap;
        logic                mem_rd;
        logic                mem_wb;
        logic [ADDR_W-1:0]   mem_addr;
        logic                mem_uncached;
        logic [2:0]          mem_size_log2;
        logic                poisoned;
        logic                ecc_error;
    } ccp_rsp_type;

    // Line state: valid, dirty, poisoned_data_marker, used
    typedef struct packed {
        logic v;
        logic d;
        logic p;
        logic u;
    } ccp_state_type;

    function automatic logic [SET_W-1:0] set_of(input logic [ADDR_W-1:0] a);
        return a[L2_OFF_W +: SET_W];
    endfunction

    function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1 -: TAG_W];
    endfunction
endpackage

// ---- ccp_state_ecc.sv ----
// SECDED code for second-level line state bits
`timescale 1ns/1ps
module ccp_state_ecc
(
    input  wire logic [ccp_pkg::ST_W-1:0]  data_in,
    input  wire logic [ccp_pkg::ECC_W-1:0] chk_in,
    output logic      [ccp_pkg::ECC_W-1:0] chk_gen,
    output logic      [ccp_pkg::ST_W-1:0]  data_cor,
    output logic                           uncorrectable
);
    // Hamming(7,4) plus overall parity
    logic [2:0] syn;
    logic       par;
    logic [ccp_pkg::ECC_W-1:0] g;

    always_comb
    begin
        g[0] = data_in[0] ^ data_in[1] ^ data_in[3];
        g[1] = data_in[0] ^ data_in[2] ^ data_in[3];
        g[2] = data_in[1] ^ data_in[2] ^ data_in[3];
        g[3] = ^data_in ^ g[0] ^ g[1] ^ g[2];
        chk_gen = g;
        syn = g[2:0] ^ chk_in[2:0];
        par = ^data_in ^ ^chk_in;
        data_cor = data_in;
        uncorrectable = (syn != 3'h0) && !par;
        if (par)
        begin
            case (syn)
                3'h3: data_cor[0] = !data_in[0];
                3'h5: data_cor[1] = !data_in[1];
                3'h6: data_cor[2] = !data_in[2];
                3'h7: data_cor[3] = !data_in[3];
                default: data_cor = data_in;
            endcase
        end
    end
endmodule

// ---- ccp_cache_policy.sv ----
// Cache policy engine: L2 lookup, fill, flush, ordering, traps, APB registers
`timescale 1ns/1ps
module ccp_cache_policy
#(
    parameter int WAYS = ccp_pkg::WAYS,
    parameter int SETS = ccp_pkg::SETS
)
(
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    input  wire logic                 req_valid,
    input  wire ccp_pkg::ccp_req_type req,
    output logic                      req_ready,
    output ccp_pkg::ccp_rsp_type      rsp,
    input  wire logic                 mem_ack,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr
);
    typedef enum { S_IDLE, S_LOOK, S_WB, S_FILL, S_L1, S_DONE } ccp_fsm_type;

    ccp_fsm_type                                fsm_r;
    ccp_pkg::ccp_req_type                       cur_r;
    ccp_pkg::ccp_rsp_type                       rsp_r;
    logic [ccp_pkg::TAG_W-1:0]                  tag_r [SETS][WAYS];
    ccp_pkg::ccp_state_type                     st_r  [SETS][WAYS];
    logic [ccp_pkg::ECC_W-1:0]                  ecc_r [SETS][WAYS];
    logic [ccp_pkg::L1D_SUB-1:0]                dir_d_r [SETS][WAYS];
    logic [ccp_pkg::L1I_SUB-1:0]                dir_i_r [SETS][WAYS];
    logic [ccp_pkg::WAY_W-1:0]                  way_r;
    logic                                       drop_r;
    logic [2:0]                                 sub_r;
    logic [1:0]                                 ctrl_r;
    logic [7:0]                                 trap_cnt_r;
    logic [31:0]                                prdata_r;
    logic                                       pready_r;
    logic                                       pslverr_r;
    logic                                       hit;
    logic [ccp_pkg::WAY_W-1:0]                  hit_way;
    logic [ccp_pkg::WAY_W-1:0]                  vic_way;
    logic [ccp_pkg::SET_W-1:0]                  set_c;
    ccp_pkg::ccp_state_type                     st_raw;
    ccp_pkg::ccp_state_type                     st_cor;
    logic [ccp_pkg::ECC_W-1:0]                  ecc_gen;
    logic                                       ecc_ue;
    logic [ccp_pkg::ECC_W-1:0]                  ecc_unused;
    logic [2:0]                                 hits;
    logic                                       apb_acc;

    assign set_c = ccp_pkg::set_of(cur_r.addr);

    // Tag compare and victim choice
    always_comb
    begin
        hits = 3'h0;
        hit_way = '0;
        vic_way = '0;
        for (int w = 0; w < WAYS; w++)
        begin
            if (st_r[set_c][w].v && tag_r[set_c][w] == ccp_pkg::tag_of(cur_r.addr))
            begin
                hit_way = ccp_pkg::WAY_W'(w);
                hits = hits + 3'h1;
            end
        end
        for (int w = WAYS - 1; w >= 0; w--)
        begin
            if (!st_r[set_c][w].u || !st_r[set_c][w].v)
                vic_way = ccp_pkg::WAY_W'(w);
        end
        // Direct-map: way taken from the address bits above the set
        if (ctrl_r[ccp_pkg::CTRL_DMAP])
            vic_way = cur_r.addr[ccp_pkg::L2_OFF_W + ccp_pkg::SET_W +: ccp_pkg::WAY_W];
        hit = hits != 3'h0;
        st_raw = st_r[set_c][hit ? hit_way : vic_way];
    end

    // State bits checked on every read
    ccp_state_ecc u_ecc
    (
        .data_in       (st_raw),
        .chk_in        (ecc_r[set_c][hit ? hit_way : vic_way]),
        .chk_gen       (ecc_unused),
        .data_cor      (st_cor),
        .uncorrectable (ecc_ue)
    );

    // Check bits for freshly written state
    function automatic logic [ccp_pkg::ECC_W-1:0] ecc_of(input logic [ccp_pkg::ST_W-1:0] d);
        logic [ccp_pkg::ECC_W-1:0] g;
        g[0] = d[0] ^ d[1] ^ d[3];
        g[1] = d[0] ^ d[2] ^ d[3];
        g[2] = d[1] ^ d[2] ^ d[3];
        g[3] = ^d ^ g[0] ^ g[1] ^ g[2];
        return g;
    endfunction
    assign ecc_gen = ecc_of(st_r[set_c][way_r]);

    assign req_ready = (fsm_r == S_IDLE);
    assign rsp       = rsp_r;
    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;

    // One request at a time keeps program order and store ordering
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            fsm_r  <= S_IDLE;
            cur_r  <= '0;
            way_r  <= '0;
            drop_r <= 1'b0;
            sub_r  <= 3'h0;
            rsp_r  <= '0;
            // Clean sets so the first lookups never read unknown state
            for (int s = 0; s < SETS; s++)
            begin
                for (int w = 0; w < WAYS; w++)
                begin
                    st_r[s][w]  <= '0;
                    ecc_r[s][w] <= '0;
                end
            end
        end
        else
        begin
            rsp_r.done <= 1'b0;
            rsp_r.l1_fill <= 1'b0;
            rsp_r.l1_inval <= 1'b0;
            rsp_r.mem_rd <= 1'b0;
            rsp_r.mem_wb <= 1'b0;
            rsp_r.side_effect_page_trap <= 1'b0;
            rsp_r.deferred_store_fault_trap <= 1'b0;
            rsp_r.multi_hit_trap <= 1'b0;
            rsp_r.nc_page_trap <= 1'b0;
            rsp_r.ecc_error <= 1'b0;
            case (fsm_r)
                S_IDLE:
                begin
                    if (req_valid)
                    begin
                        cur_r <= req;
                        fsm_r <= S_LOOK;
                    end
                end
                S_LOOK:
                begin
                    way_r <= hit ? hit_way : vic_way;
                    sub_r <= 3'h0;
                    fsm_r <= S_DONE;
                    if (cur_r.multi_hit || hits > 3'h1)
                        rsp_r.multi_hit_trap <= 1'b1;
                    else if (cur_r.sb_ue)
                        rsp_r.deferred_store_fault_trap <= 1'b1;
                    else if (ecc_ue)
                        rsp_r.ecc_error <= 1'b1;
                    else if (cur_r.speculative && cur_r.side_effect && cur_r.op == ccp_pkg::CCP_LOAD)
                        rsp_r.side_effect_page_trap <= 1'b1;
                    else if (cur_r.op == ccp_pkg::CCP_ATOMIC && !cur_r.cacheable)
                        rsp_r.nc_page_trap <= 1'b1;
                    else if (cur_r.op == ccp_pkg::CCP_LOOKASIDE)
                        fsm_r <= S_DONE;
                    else if (!cur_r.cacheable || !ctrl_r[ccp_pkg::CTRL_L2_EN])
                    begin
                        // Outside the coherence domain: direct transfer of the requested size
                        rsp_r.mem_rd <= 1'b1;
                        rsp_r.mem_uncached <= 1'b1;
                        rsp_r.mem_addr <= cur_r.addr;
                        rsp_r.mem_size_log2 <= cur_r.size_log2;
                        fsm_r <= S_FILL;
                    end
                    else if (cur_r.op == ccp_pkg::CCP_DIAG_INV)
                    begin
                        if (hit)
                            st_r[set_c][hit_way].v <= 1'b0;
                    end
                    else if (cur_r.op == ccp_pkg::CCP_PREFETCH && cur_r.fcn == ccp_pkg::PF_INVAL_FCN)
                    begin
                        if (hit)
                        begin
                            drop_r <= 1'b1;
                            fsm_r <= st_cor.d ? S_WB : S_L1;
                        end
                    end
                    else if (hit)
                    begin
                        // Side-effect pages stay cacheable here
                        st_r[set_c][hit_way].u <= 1'b1;
                        if (cur_r.op == ccp_pkg::CCP_STORE || cur_r.op == ccp_pkg::CCP_ATOMIC)
                            st_r[set_c][hit_way].d <= 1'b1;
                        rsp_r.poisoned <= st_cor.p;
                        fsm_r <= S_L1;
                    end
                    else
                    begin
                        drop_r <= 1'b0;
                        fsm_r <= (st_cor.v && st_cor.d) ? S_WB : S_FILL;
                        if (!(st_cor.v && st_cor.d))
                        begin
                            rsp_r.mem_rd <= 1'b1;
                            rsp_r.mem_uncached <= 1'b0;
                            rsp_r.mem_size_log2 <= 3'(ccp_pkg::L2_OFF_W);
                            rsp_r.mem_addr <= {cur_r.addr[ccp_pkg::ADDR_W-1:ccp_pkg::L2_OFF_W],
                                               ccp_pkg::L2_OFF_W'(0)};
                        end
                    end
                end
                S_WB:
                begin
                    // Dirty line leaves before it is dropped
                    rsp_r.mem_wb <= !mem_ack;
                    rsp_r.mem_uncached <= 1'b0;
                    rsp_r.mem_size_log2 <= 3'(ccp_pkg::L2_OFF_W);
                    rsp_r.mem_addr <= {tag_r[set_c][way_r], set_c, ccp_pkg::L2_OFF_W'(0)};
                    if (mem_ack)
                    begin
                        st_r[set_c][way_r].d <= 1'b0;
                        fsm_r <= drop_r ? S_L1 : S_FILL;
                        // Victim is out; a miss now fetches its own line
                        rsp_r.mem_rd <= !drop_r;
                        rsp_r.mem_addr <= {cur_r.addr[ccp_pkg::ADDR_W-1:ccp_pkg::L2_OFF_W],
                                           ccp_pkg::L2_OFF_W'(0)};
                    end
                end
                S_FILL:
                begin
                    if (mem_ack)
                    begin
                        if (rsp_r.mem_uncached)
                            fsm_r <= S_DONE;
                        else
                        begin
                            tag_r[set_c][way_r] <= ccp_pkg::tag_of(cur_r.addr);
                            st_r[set_c][way_r] <= '{v: 1'b1, d: cur_r.op != ccp_pkg::CCP_LOAD,
                                                   p: 1'b0, u: 1'b1};
                            dir_d_r[set_c][way_r] <= '0;
                            dir_i_r[set_c][way_r] <= '0;
                            fsm_r <= S_L1;
                        end
                    end
                    else
                        rsp_r.mem_rd <= 1'b1;
                end
                S_L1:
                begin
                    // Inclusion sweep of first-level data blocks covered by a dropped line; instruction blocks only leave the directory
                    if (drop_r || (!hit && st_cor.v && !rsp_r.mem_rd && sub_r != 3'h0))
                    begin
                        rsp_r.l1_inval <= dir_d_r[set_c][way_r][sub_r[1:0]];
                        rsp_r.l1_instr <= 1'b0;
                        rsp_r.l1_addr <= {cur_r.addr[ccp_pkg::ADDR_W-1:ccp_pkg::L2_OFF_W],
                                          sub_r[1:0], ccp_pkg::L1D_OFF_W'(0)};
                        dir_d_r[set_c][way_r][sub_r[1:0]] <= 1'b0;
                        if (sub_r[1:0] < 2'(ccp_pkg::L1I_SUB))
                            dir_i_r[set_c][way_r][sub_r[0]] <= 1'b0;
                        sub_r <= sub_r + 3'h1;
                        if (sub_r == 3'(ccp_pkg::L1D_SUB - 1))
                        begin
                            st_r[set_c][way_r].v <= 1'b0;
                            drop_r <= 1'b0;
                            fsm_r <= S_DONE;
                        end
                    end
                    else if (cur_r.op == ccp_pkg::CCP_ATOMIC)
                    begin
                        // Atomics live only in the second level
                        rsp_r.l1_inval <= 1'b1;
                        rsp_r.l1_instr <= 1'b0;
                        rsp_r.l1_addr <= cur_r.addr;
                        dir_d_r[set_c][way_r] <= '0;
                        dir_i_r[set_c][way_r] <= '0;
                        fsm_r <= S_DONE;
                    end
                    else if (cur_r.cp && cur_r.op == ccp_pkg::CCP_LOAD)
                    begin
                        rsp_r.l1_fill <= 1'b1;
                        rsp_r.l1_instr <= cur_r.instr;
                        rsp_r.l1_addr <= cur_r.addr;
                        if (cur_r.instr)
                            dir_i_r[set_c][way_r][cur_r.addr[ccp_pkg::L1I_OFF_W]] <= 1'b1;
                        else
                            dir_d_r[set_c][way_r][cur_r.addr[ccp_pkg::L1D_OFF_W +: 2]] <= 1'b1;
                        fsm_r <= S_DONE;
                    end
                    else
                        fsm_r <= S_DONE;
                end
                S_DONE:
                begin
                    rsp_r.done <= 1'b1;
                    rsp_r.mem_uncached <= 1'b0;
                    if (!rsp_r.ecc_error)
                        ecc_r[set_c][way_r] <= ecc_gen;
                    fsm_r <= S_IDLE;
                end
                default:
                    fsm_r <= S_IDLE;
            endcase
        end
    end

    // APB slave: one wait state, unmapped addresses flag an error
    assign apb_acc = psel && penable && !pready_r;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ctrl_r    <= ccp_pkg::CTRL_RESET;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= apb_acc;
            pslverr_r <= 1'b0;
            if (apb_acc)
            begin
                prdata_r <= 32'h0000_0000;
                if (paddr == ccp_pkg::REG_CTRL)
                begin
                    if (pwrite)
                        ctrl_r <= pwdata[1:0];
                    prdata_r <= {30'h0, ctrl_r};
                end
                else if (paddr == ccp_pkg::REG_STATUS)
                    prdata_r <= {29'h0, ccp_pkg::ST_W'(0) == 4'h0, req_ready, fsm_r != S_IDLE};
                else if (paddr == ccp_pkg::REG_COUNT)
                    prdata_r <= {24'h0, trap_cnt_r};
                else
                    pslverr_r <= 1'b1;
            end
        end
    end

    // Trap counter for software visibility
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            trap_cnt_r <= 8'h00;
        else if (rsp_r.multi_hit_trap || rsp_r.side_effect_page_trap || rsp_r.deferred_store_fault_trap)
            trap_cnt_r <= trap_cnt_r + 8'h01;
    end
endmodule

// ---- ccp_cache_policy_checker.sv ----
// Port checker for the cache policy engine
`timescale 1ns/1ps
module ccp_cache_policy_checker
#(
    parameter int WAYS = ccp_pkg::WAYS,
    parameter int SETS = ccp_pkg::SETS
)
(
    input wire logic                 clk_sys,
    input wire logic                 srst,
    input wire logic                 req_valid,
    input wire ccp_pkg::ccp_req_type req,
    input wire logic                 req_ready,
    input wire ccp_pkg::ccp_rsp_type rsp,
    input wire logic                 mem_ack,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence taken;
        req_valid && req_ready;
    endsequence
    sequence spec_side;
        taken ##0 (req.op == ccp_pkg::CCP_LOAD && req.speculative && req.side_effect && !req.multi_hit && !req.sb_ue);
    endsequence
    a_one_inflight: assert property (taken |=> !req_ready) else $error("request taken while busy");
    a_done_bound: assert property (taken |-> ##[3:200] rsp.done) else $error("request never done");
    a_spec_trap: assert property (spec_side |-> ##[1:8] rsp.side_effect_page_trap) else $error("no trap");
    a_spec_nomem: assert property (spec_side |=> !rsp.mem_rd until rsp.done) else $error("load done");
    a_multi_trap: assert property (taken ##0 req.multi_hit |-> ##[1:8] rsp.multi_hit_trap)
        else $error("multi hit not trapped");
    a_store_fault: assert property (taken ##0 (req.sb_ue && !req.multi_hit) |-> ##[1:8] rsp.deferred_store_fault_trap)
        else $error("store fault not trapped");
    a_no_fill: assert property (taken ##0 (!req.cp || req.op == ccp_pkg::CCP_ATOMIC) |=> !rsp.l1_fill until rsp.done)
        else $error("first level filled");
    a_diag_quiet: assert property (taken ##0 (req.op == ccp_pkg::CCP_DIAG_INV) |=>
        !(rsp.mem_wb || rsp.l1_inval) until rsp.done) else $error("diagnostic side effect");
    a_mem_hold: assert property ((rsp.mem_rd || rsp.mem_wb) && !mem_ack |=>
        (rsp.mem_rd || rsp.mem_wb) && $stable(rsp.mem_addr)) else $error("memory request dropped");
    a_apb_ready: assert property (psel && penable && !pready |=> pready) else $error("apb wait too long");
endmodule

bind ccp_cache_policy ccp_cache_policy_checker #(.WAYS(WAYS), .SETS(SETS)) u_chk (.clk_sys(clk_sys), .srst(srst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp(rsp), .mem_ack(mem_ack), .psel(psel),
    .penable(penable), .pready(pready));

// ---- ccp_strand_model.sv ----
// Processor strand model issuing one request at a time
`timescale 1ns/1ps
module ccp_strand_model
(
    input  wire logic                 clk_sys,
    output ccp_pkg::ccp_req_type      req,
    output logic                      req_valid,
    input  wire logic                 req_ready,
    input  wire ccp_pkg::ccp_rsp_type rsp
);
    initial
    begin
        req_valid = 1'b0;
        req = '0;
    end
    // Gathers every pulse of the answer until done
    task automatic issue(input ccp_pkg::ccp_req_type r, output ccp_pkg::ccp_rsp_type seen);
        int   n;
        seen = '0;
        n = 0;
        if (r.op == ccp_pkg::CCP_ATOMIC) r.cacheable = 1'b1;
        @(posedge clk_sys);
        req <= r;
        req_valid <= 1'b1;
        do
            @(posedge clk_sys);
        while (!req_ready);
        req_valid <= 1'b0;
        // Stale fields must not look valid
        req <= ~r;
        while (!seen.done && n < 400)
        begin
            @(posedge clk_sys);
            seen = seen | rsp;
            n++;
        end
    endtask
endmodule

// ---- ccp_cache_policy_tb.sv ----
// Bench: APB registers and request policy table
`timescale 1ns/1ps
module ccp_cache_policy_tb;
    logic                 clk_sys = 1'b0;
    logic                 srst = 1'b1;
    logic                 req_valid, req_ready, pready, pslverr, err;
    logic                 mem_ack = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0000_0000;
    logic [31:0]          prdata, rd;
    ccp_pkg::ccp_req_type req;
    ccp_pkg::ccp_rsp_type rsp, seen;
    int                   n_errors = 0;
    int                   n_tests = 0;
    always #2.5 clk_sys = ~clk_sys;
    ccp_cache_policy DUT (.clk_sys(clk_sys), .srst(srst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp(rsp), .mem_ack(mem_ack), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ccp_strand_model u_strand (.clk_sys(clk_sys), .req(req), .req_valid(req_valid), .req_ready(req_ready), .rsp(rsp));
    // Memory accepts each request one cycle after it appears
    always @(posedge clk_sys)
        mem_ack <= (rsp.mem_rd || rsp.mem_wb) && !mem_ack;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (!pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Result bits: done, fill, inval, mem_rd, mem_wb, side-effect, store fault, multi-hit
    task automatic run(input ccp_pkg::ccp_op_type op, input logic [29:0] a, input logic [5:0] f,
                       input logic [7:0] m, input logic [7:0] e);
        ccp_pkg::ccp_req_type r;
        r = '0;
        r.op = op;
        r.addr = a;
        {r.cp, r.cacheable, r.side_effect, r.speculative, r.multi_hit, r.sb_ue} = f;
        r.fcn = (op == ccp_pkg::CCP_PREFETCH) ? ccp_pkg::PF_INVAL_FCN : 5'h00;
        u_strand.issue(r, seen);
        chk({seen.done, seen.l1_fill, seen.l1_inval, seen.mem_rd, seen.mem_wb, seen.side_effect_page_trap,
             seen.deferred_store_fault_trap, seen.multi_hit_trap} & m, e);
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        apb(1'b0, ccp_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, ccp_pkg::REG_STATUS, 32'h0);
        chk(rd[2:1], 2'h3);
        apb(1'b0, 12'h00C, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, ccp_pkg::REG_CTRL, 32'h0000_0003);
        apb(1'b0, ccp_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h0000_0003);
        apb(1'b1, ccp_pkg::REG_CTRL, 32'h0000_0001);
        $display("Test registers done");
        run(ccp_pkg::CCP_LOAD, 30'h0001000, 6'h30, 8'hFF, 8'hD0);
        run(ccp_pkg::CCP_STORE, 30'h0001000, 6'h30, 8'h87, 8'h80);
        run(ccp_pkg::CCP_DIAG_INV, 30'h0001000, 6'h30, 8'hFF, 8'h80);
        run(ccp_pkg::CCP_LOAD, 30'h0002000, 6'h30, 8'hFF, 8'hD0);
        run(ccp_pkg::CCP_STORE, 30'h0002000, 6'h30, 8'h87, 8'h80);
        run(ccp_pkg::CCP_PREFETCH, 30'h0002000, 6'h30, 8'hFF, 8'hA8);
        run(ccp_pkg::CCP_LOAD, 30'h0003000, 6'h10, 8'hFF, 8'h90);
        run(ccp_pkg::CCP_LOAD, 30'h0003000, 6'h10, 8'hFF, 8'h80);
        run(ccp_pkg::CCP_LOAD, 30'h0004000, 6'h00, 8'hC7, 8'h80);
        run(ccp_pkg::CCP_LOAD, 30'h0005000, 6'h0C, 8'hFF, 8'h84);
        run(ccp_pkg::CCP_LOAD, 30'h0006000, 6'h38, 8'hFF, 8'hD0);
        run(ccp_pkg::CCP_LOAD, 30'h0007000, 6'h32, 8'h87, 8'h81);
        run(ccp_pkg::CCP_STORE, 30'h0008000, 6'h31, 8'h87, 8'h82);
        run(ccp_pkg::CCP_ATOMIC, 30'h0009000, 6'h30, 8'hFF, 8'hB0);
        run(ccp_pkg::CCP_LOOKASIDE, 30'h0000000, 6'h00, 8'hFF, 8'h80);
        apb(1'b1, ccp_pkg::REG_CTRL, 32'h0000_0003);
        run(ccp_pkg::CCP_LOAD, 30'h000A800, 6'h30, 8'hFF, 8'hD8);
        run(ccp_pkg::CCP_LOAD, 30'h0006000, 6'h10, 8'hFF, 8'h80);
        apb(1'b0, ccp_pkg::REG_COUNT, 32'h0);
        chk(rd, 32'h0000_0003);
        $display("Test requests done");
        give_verdict;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        give_verdict;
    end
endmodule
